//--- shared/port_pull_defs.svh
// Constants for the port direction, pull and clock output block.
// Assumes a byte-wide register port with a 10-bit address.
`ifndef PORT_PULL_DEFS_SVH
`define PORT_PULL_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W           10
`define SECOND_DATA_OFS  10'h001
`define SECOND_DIR_OFS   10'h003
`define PULL_CTRL_OFS    10'h00c
`define CLK_CTRL_OFS     10'h00d

// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define BYTE_ZERO        8'h00
`define PULL_WR_MASK     8'h03
`define CLK_CTRL_MASK    8'hbf

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DEBUG_PULLUP_BIT 6
`define SECOND_PD_BIT    1
`define FIRST_PD_BIT     0
`define CLK_DISABLE_BIT  7
`define EXTRA_SIXTEEN_DIVIDER_ENABLE_BIT        5
`define DIV_MSB          4
`define DIV_LSB          0

// ----------------------------------------------------------------
// Divider sizes
// ----------------------------------------------------------------
`define DIV_W            5
`define SIXTEEN_W        4
`define SIXTEEN_HALF     3

`endif

//--- shared/port_pull_pkg.sv
// Types shared by the port direction, pull and clock output block.
// Assumes the constants header is included by each design file.
package port_pull_pkg;

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_DATA,
    SEL_DIR,
    SEL_PULL,
    SEL_CLK
  } regSel_t;

  // Byte of register data
  typedef logic [7:0] byte_t;

endpackage : port_pull_pkg

//--- src/clock_out_divider.sv
// Free-running clock output generator with two divider stages.
// Assumes one bus clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "port_pull_defs.svh"

module clock_out_divider
  import port_pull_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Control from the register file
  input  wire logic [`DIV_W-1:0]   divField,
  input  wire logic                div16En,
  input  wire logic                outEnable,
  // Pad side, all registered
  output logic                     clkOut,
  output logic                     clkOutOe,
  output logic                     clkOutBypass
);

  // ----------------------------------------------------------------
  // Stage counters
  // ----------------------------------------------------------------
  logic [`DIV_W-1:0]     divCnt_q;     // First stage position
  logic [`DIV_W-1:0]     divCnt_d;
  logic [`SIXTEEN_W-1:0] sixteen_q;    // Second stage position
  logic [`SIXTEEN_W-1:0] sixteen_d;
  logic                  tick;         // End of one first-stage period
  logic                  halfHigh;     // High part of first stage
  logic [`DIV_W:0]       highLen;      // Cycles high per period
  logic                  phase_d;
  logic                  bypass_d;

  // ----------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------
  // R13 divide by field plus one
  // Compare with >= so a lowered field recovers at once
  assign tick     = divCnt_q >= divField;
  assign divCnt_d = tick ? '0 : divCnt_q + 1'b1;
  // High for the larger half when the period is odd
  assign highLen  = 6'((({1'b0, divField} + 6'h02)) >> 1);
  assign halfHigh = {1'b0, divCnt_q} < highLen;
  // R12 sixteen stage after divider
  assign sixteen_d = tick ? sixteen_q + 1'b1 : sixteen_q;
  // R11 disable holds pin low
  assign phase_d  = !outEnable ? 1'b0 :
                    div16En ? !sixteen_q[`SIXTEEN_HALF] : halfHigh;
  // Undivided rate cannot come from a flop; the pad muxes the clock
  assign bypass_d = outEnable && !div16En && (divField == '0);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Counters run free, even while the pin is disabled
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt_q     <= '0;
      sixteen_q    <= '0;
      clkOut       <= 1'b0;
      clkOutOe     <= 1'b0;
      clkOutBypass <= 1'b0;
    end else begin
      divCnt_q     <= divCnt_d;
      sixteen_q    <= sixteen_d;
      clkOut       <= phase_d;
      clkOutOe     <= outEnable;
      clkOutBypass <= bypass_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence fieldSteady_s;
    $stable(divField) ##1 $stable(divField);
  endsequence

  cnt_range_a : assert property ( // R13
    fieldSteady_s |-> divCnt_q <= divField)
    else $error("divider count beyond field");

  sixteen_step_a : assert property ( // R12
    !tick |=> sixteen_q == $past(sixteen_q))
    else $error("sixteen stage moved without tick");

endmodule : clock_out_divider

//--- src/port_dir_pull_clock_out.sv
// Second-port direction, port pull controls and clock output.
// Assumes a one-cycle register port on the bus clock and pads
// that resolve output enable, pulls and the clock bypass.
`timescale 1ns/1ps
`include "port_pull_defs.svh"

// Notes on behaviour
// R1 - direction bit one drives, zero receives
// R2 - enabled segment disables input and output
// R3 - data read may lag direction change
// R4 - direction register read/write, resets to zero
// R5 - reserved slots read zero, ignore writes
// R6 - debug pull-up writable only in special mode
// R7 - debug pin pull-up when input
// R8 - second port pull-downs on inputs
// R9 - first port pull-downs on inputs
// R10 - pulls never act on outputs
// R11 - clock output bit seven disables
// R12 - bit five adds divide by sixteen
// R13 - divider field plus one divides
// R14 - software avoids undivided fast clock
// R15 - data read: register if output, else pin
// R16 - pull and clock controls reset zero
module port_dir_pull_clock_out
  import port_pull_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [`ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [7:0]          regRdData,
  // Mode and neighbouring logic
  input  wire logic                specialSingleChip,
  input  wire logic [7:0]          firstPortDir,
  input  wire logic [7:0]          firstPortSeg,
  input  wire logic [7:0]          secondPortSeg,
  input  wire logic                debugPinIsInput,
  // Second port pads
  input  wire logic [7:0]          secondPortPin,
  output logic      [7:0]          secondPortOut,
  output logic      [7:0]          secondPortOe,
  output logic      [7:0]          secondPortInEn,
  output logic      [7:0]          secondPortPullDown,
  // First port and debug pin pull controls
  output logic      [7:0]          firstPortPullDown,
  output logic                     debugPinPullUp,
  // Clock output pad
  output logic                     clkOut,
  output logic                     clkOutOe,
  output logic                     clkOutBypass
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Pins that act as inputs: not driven and no segment on them
  function automatic byte_t pinIsInput(byte_t dir, byte_t seg);
    pinIsInput = ~dir & ~seg;
  endfunction : pinIsInput

  // Pull devices only where the pin is an input
  function automatic byte_t pullMask(logic en, byte_t dir,
                                     byte_t seg);
    pullMask = en ? pinIsInput(dir, seg) : `BYTE_ZERO;
  endfunction : pullMask

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  byte_t   secondPortData_q;   // Second port output data
  byte_t   secondPortDir_q;    // Second port direction bits
  byte_t   pullControl_q;      // Pull enables
  byte_t   clkOutControl_q;    // Clock output control
  byte_t   pinMeta_q;          // First synchroniser stage
  byte_t   pinSync_q;          // Second synchroniser stage

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  regSel_t regSel;             // Which register the address hits
  logic    wrData;
  logic    wrDir;
  logic    wrPull;
  logic    wrClk;

  // R5 unmapped slots select nothing
  assign regSel = (regAddr == `SECOND_DATA_OFS) ? SEL_DATA :
                  (regAddr == `SECOND_DIR_OFS)  ? SEL_DIR  :
                  (regAddr == `PULL_CTRL_OFS)   ? SEL_PULL :
                  (regAddr == `CLK_CTRL_OFS)    ? SEL_CLK  :
                                                  SEL_NONE;

  assign wrData = regWr && (regSel == SEL_DATA);
  assign wrDir  = regWr && (regSel == SEL_DIR);
  assign wrPull = regWr && (regSel == SEL_PULL);
  assign wrClk  = regWr && (regSel == SEL_CLK);

  // ----------------------------------------------------------------
  // Write data shaping
  // ----------------------------------------------------------------
  byte_t   pullWrite;          // Pull value after the mode guard
  byte_t   clkWrite;           // Clock control, unused bit cleared
  logic    debugPullNext;      // Debug pull-up bit to store

  // R6 debug pull-up bit only in special mode
  assign debugPullNext = specialSingleChip ?
                         regWrData[`DEBUG_PULLUP_BIT] :
                         pullControl_q[`DEBUG_PULLUP_BIT];

  always_comb begin
    pullWrite = regWrData & `PULL_WR_MASK;
    pullWrite[`DEBUG_PULLUP_BIT] = debugPullNext;
  end

  assign clkWrite = regWrData & `CLK_CTRL_MASK;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  byte_t   dataView;           // Port data as software sees it
  byte_t   readMux;            // Value for the selected register

  // R15 outputs read the register, inputs read the pin
  // R3 pin path is two flops behind, so reads lag
  assign dataView = (secondPortDir_q & secondPortData_q) |
                    (~secondPortDir_q & pinSync_q);

  assign readMux = (regSel == SEL_DATA) ? dataView        :
                   (regSel == SEL_DIR)  ? secondPortDir_q :
                   (regSel == SEL_PULL) ? pullControl_q   :
                   (regSel == SEL_CLK)  ? clkOutControl_q :
                                          `BYTE_ZERO;

  // ----------------------------------------------------------------
  // Pad decode
  // ----------------------------------------------------------------
  byte_t   outEnNext;          // Drive enables before the flop
  byte_t   inEnNext;           // Input buffer enables
  byte_t   secondPullNext;     // Second port pull-downs
  byte_t   firstPullNext;      // First port pull-downs
  logic    debugPullUpNext;    // Debug pin pull-up

  // R1 direction bit one drives the pin
  // R2 segment forces both buffers off
  assign outEnNext = secondPortDir_q & ~secondPortSeg;
  assign inEnNext  = ~secondPortSeg;

  // R8 second port pull-downs on inputs
  // R10 mask drops pins that drive
  assign secondPullNext = pullMask(pullControl_q[`SECOND_PD_BIT],
                                   secondPortDir_q, secondPortSeg);

  // R9 first port pull-downs on inputs
  assign firstPullNext = pullMask(pullControl_q[`FIRST_PD_BIT],
                                  firstPortDir, firstPortSeg);

  // R7 debug pull-up only while an input
  assign debugPullUpNext = pullControl_q[`DEBUG_PULLUP_BIT] &&
                           debugPinIsInput;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // R4 direction resets to all inputs
  // R16 pull and clock controls reset zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secondPortData_q <= `BYTE_ZERO;
      secondPortDir_q  <= `BYTE_ZERO;
      pullControl_q    <= `BYTE_ZERO;
      clkOutControl_q  <= `BYTE_ZERO;
    end else begin
      if (wrData) begin
        secondPortData_q <= regWrData;
      end
      if (wrDir) begin
        secondPortDir_q <= regWrData;
      end
      if (wrPull) begin
        pullControl_q <= pullWrite;
      end
      if (wrClk) begin
        clkOutControl_q <= clkWrite;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= `BYTE_ZERO;
    end else begin
      regRdData <= regRd ? readMux : `BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage is read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinMeta_q <= `BYTE_ZERO;
      pinSync_q <= `BYTE_ZERO;
    end else begin
      pinMeta_q <= secondPortPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pad registers
  // ----------------------------------------------------------------
  // Registered so the pads see no decode glitches
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secondPortOut      <= `BYTE_ZERO;
      secondPortOe       <= `BYTE_ZERO;
      secondPortInEn     <= `BYTE_ZERO;
      secondPortPullDown <= `BYTE_ZERO;
      firstPortPullDown  <= `BYTE_ZERO;
      debugPinPullUp     <= 1'b0;
    end else begin
      secondPortOut      <= secondPortData_q;
      secondPortOe       <= outEnNext;
      secondPortInEn     <= inEnNext;
      secondPortPullDown <= secondPullNext;
      firstPortPullDown  <= firstPullNext;
      debugPinPullUp     <= debugPullUpNext;
    end
  end

  // ----------------------------------------------------------------
  // Clock output
  // ----------------------------------------------------------------
  // R11 bit seven low enables the pin
  // R14 at this bus rate undivided output is safe
  clock_out_divider clock_out_divider_inst (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .divField     (clkOutControl_q[`DIV_MSB:`DIV_LSB]),
    .div16En      (clkOutControl_q[`EXTRA_SIXTEEN_DIVIDER_ENABLE_BIT]),
    .outEnable    (!clkOutControl_q[`CLK_DISABLE_BIT]),
    .clkOut       (clkOut),
    .clkOutOe     (clkOutOe),
    .clkOutBypass (clkOutBypass)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  dir_drive_a : assert property ( // R1
    secondPortOe == $past(secondPortDir_q & ~secondPortSeg))
    else $error("drive enable does not follow direction");

  seg_off_a : assert property ( // R2
    |secondPortSeg |=>
      ((secondPortOe | secondPortInEn) & $past(secondPortSeg)) == 0)
    else $error("segment pin not fully disabled");

  dir_write_a : assert property ( // R4
    wrDir |=> secondPortDir_q == $past(regWrData))
    else $error("direction write lost");

  reserved_zero_a : assert property ( // R5
    regRd && regSel == SEL_NONE |=> regRdData == 0)
    else $error("reserved slot read nonzero");

  debug_guard_a : assert property ( // R6
    wrPull && !specialSingleChip |=> $stable(
      pullControl_q[`DEBUG_PULLUP_BIT]))
    else $error("debug pull-up written outside special mode");

  debug_pull_a : assert property ( // R7
    debugPinPullUp == $past(pullControl_q[`DEBUG_PULLUP_BIT]
                            && debugPinIsInput))
    else $error("debug pull-up mismatch");

  second_pull_a : assert property ( // R8
    secondPortPullDown == $past({8{pullControl_q[`SECOND_PD_BIT]}}
                                & ~secondPortDir_q & ~secondPortSeg))
    else $error("second port pull-down mismatch");

  first_pull_a : assert property ( // R9
    !pullControl_q[`FIRST_PD_BIT] |=> firstPortPullDown == 0)
    else $error("first port pull-down while disabled");

  pull_out_a : assert property ( // R10
    (secondPortPullDown & secondPortOe) == 0)
    else $error("pull-down on a driven pin");

  clk_off_a : assert property ( // R11
    clkOutControl_q[`CLK_DISABLE_BIT] [*2] |-> !clkOutOe && !clkOut)
    else $error("clock output active while disabled");

  read_mux_a : assert property ( // R15
    regRd && regSel == SEL_DATA |=> regRdData == $past(dataView))
    else $error("port data read wrong source");

  read_lag_a : assert property ( // R3
    $stable(secondPortPin) [*3] ##0 regRd && regSel == SEL_DATA
      && !secondPortDir_q[0] |=> regRdData[0] == $past(
      secondPortPin[0], 3))
    else $error("pin read not settled after two cycles");

  reset_ctrl_a : assert property ( // R16
    $past(!rst_n) |-> pullControl_q == 0 && clkOutControl_q == 0)
    else $error("controls not zero after reset");

endmodule : port_dir_pull_clock_out

//--- testbench/board_pin_model.sv
// Board model for the second port pads: drivers, pulls, floating.
// Assumes the bench sets the board drivers on the bus clock.
`timescale 1ns/1ps

module board_pin_model
  import port_pull_pkg::*;
(
  // Clock
  input  wire logic  core_clk,
  // Pad controls from the block
  input  wire byte_t padOut,
  input  wire byte_t padOe,
  input  wire byte_t padPullDown,
  // Board drivers set by the bench
  input  wire byte_t extLevel,
  input  wire byte_t extDrive,
  // Resolved pin levels
  output byte_t      pinLevel
);
  // ----------------------------------------------------------------
  // Floating lines
  // ----------------------------------------------------------------
  // Changes every cycle, so no stale level passes for a real one
  byte_t float_q = 8'h55;

  // Free toggle of the float pattern
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Pad drive wins, then board drive; a pull-down alone gives zero
  assign pinLevel = (padOe & padOut) | (~padOe & extDrive & extLevel)
                  | (~padOe & ~extDrive & ~padPullDown & float_q);

endmodule : board_pin_model

//--- testbench/port_dir_pull_clock_out_test.sv
// Bench for the port direction, pull and clock output block.
// Assumes the board model resolves pad levels on the second port.
`timescale 1ns/1ps
`include "port_pull_defs.svh"

module port_dir_pull_clock_out_test
  import port_pull_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic               core_clk;           // Bus clock, 40 ns
  logic               rst_n;              // Synchronous reset
  logic [`ADDR_W-1:0] regAddr;            // Register address
  byte_t              regWrData;          // Write data
  logic               regWr;              // Write strobe
  logic               regRd;              // Read strobe
  byte_t              regRdData;          // Read data
  logic               specialSingleChip;  // Mode level
  byte_t              firstPortDir;       // First port direction
  byte_t              firstPortSeg;       // First port segments
  byte_t              secondPortSeg;      // Second port segments
  logic               debugPinIsInput;    // Debug pin as input
  byte_t              secondPortPin;      // Resolved pad levels
  byte_t              secondPortOut;      // Pad data
  byte_t              secondPortOe;       // Pad drive enables
  byte_t              secondPortInEn;     // Pad input enables
  byte_t              secondPortPullDown; // Second port pulls
  byte_t              firstPortPullDown;  // First port pulls
  logic               debugPinPullUp;     // Debug pin pull-up
  logic               clkOut;             // Divided clock
  logic               clkOutOe;           // Clock pin drive
  logic               clkOutBypass;       // Undivided clock select
  byte_t              extLevel;           // Board drive level
  byte_t              extDrive;           // Board drive enables
  byte_t              rdVal;              // Last read value
  int                 per;                // Measured period
  int                 errTotal = 0;       // Mismatches
  int                 totalChecks = 0;    // Comparisons
  int                 cycleCount = 0;     // Timeout counter
  int                 fld [7] = '{1, 2, 31, 0, 1, 2, 31};
  int                 d16 [7] = '{0, 0, 0, 1, 1, 1, 1};

  port_dir_pull_clock_out port_dir_pull_clock_out_inst (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .specialSingleChip(specialSingleChip),
    .firstPortDir(firstPortDir), .firstPortSeg(firstPortSeg),
    .secondPortSeg(secondPortSeg), .debugPinIsInput(debugPinIsInput),
    .secondPortPin(secondPortPin), .secondPortOut(secondPortOut),
    .secondPortOe(secondPortOe), .secondPortInEn(secondPortInEn),
    .secondPortPullDown(secondPortPullDown),
    .firstPortPullDown(firstPortPullDown),
    .debugPinPullUp(debugPinPullUp), .clkOut(clkOut),
    .clkOutOe(clkOutOe), .clkOutBypass(clkOutBypass));

  board_pin_model board_pin_model_inst (
    .core_clk(core_clk), .padOut(secondPortOut), .padOe(secondPortOe),
    .padPullDown(secondPortPullDown), .extLevel(extLevel),
    .extDrive(extDrive), .pinLevel(secondPortPin));

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Ceiling well above the longest divider sweep
  always @(posedge core_clk) begin
    cycleCount++;
    if (cycleCount == 40000) begin
      errTotal++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      errTotal++;
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr(input logic [`ADDR_W-1:0] a, input byte_t d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [`ADDR_W-1:0] a, output byte_t d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask : rd

  // Read and compare in one go
  task automatic rdc(input logic [`ADDR_W-1:0] a, input byte_t e);
    rd(a, rdVal);
    check(16'(rdVal), 16'(e));
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  // Cycles from one rising clock output edge to the next
  task automatic measure(output int cyc);
    int   n;
    int   edges;
    logic prev;
    cyc = 0;
    edges = 0;
    prev = clkOut;
    for (n = 0; n < 2000 && edges < 2; n++) begin
      @(negedge core_clk);
      if (clkOut === 1'b1 && prev === 1'b0) edges++;
      if (edges == 1) cyc++;
      prev = clkOut;
    end
  endtask : measure

  task automatic report_and_stop();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    specialSingleChip = 1'b0;
    firstPortDir = 8'h00;
    firstPortSeg = 8'h00;
    secondPortSeg = 8'h00;
    debugPinIsInput = 1'b1;
    extLevel = 8'hff;
    extDrive = 8'hff;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    idle(2);
    rdc(`SECOND_DIR_OFS, 8'h00);
    rdc(`PULL_CTRL_OFS, 8'h00);
    rdc(`CLK_CTRL_OFS, 8'h00);
    check(16'({clkOutOe, clkOutBypass}), 16'h0003);
    // Direction and pad drive
    wr(`SECOND_DIR_OFS, 8'ha5);
    rdc(`SECOND_DIR_OFS, 8'ha5);
    wr(`SECOND_DATA_OFS, 8'h3c);
    idle(2);
    check(16'(secondPortOe), 16'h00a5);
    check(16'(secondPortOut), 16'h003c);
    check(16'(secondPortInEn), 16'h00ff);
    // Segments override the direction bits
    @(posedge core_clk);
    secondPortSeg <= 8'h0f;
    idle(2);
    check(16'(secondPortOe), 16'h00a0);
    check(16'(secondPortInEn), 16'h00f0);
    @(posedge core_clk);
    secondPortSeg <= 8'h00;
    // Data read mixes register bits and pin levels
    rdc(`SECOND_DATA_OFS, 8'h7e);
    @(posedge core_clk);
    extLevel <= 8'h00;
    idle(3);
    rdc(`SECOND_DATA_OFS, 8'h24);
    // Direction turn-round settles after the pad flop and the sync delay
    wr(`SECOND_DIR_OFS, 8'h00);
    idle(4);
    rdc(`SECOND_DATA_OFS, 8'h00);
    @(posedge core_clk);
    extLevel <= 8'hff;
    wr(`SECOND_DIR_OFS, 8'hff);
    idle(4);
    rdc(`SECOND_DATA_OFS, 8'h3c);
    // Pulls: debug bit locked outside special mode
    wr(`SECOND_DIR_OFS, 8'h0f);
    @(posedge core_clk);
    firstPortDir <= 8'h0f;
    firstPortSeg <= 8'h10;
    wr(`PULL_CTRL_OFS, 8'h43);
    rdc(`PULL_CTRL_OFS, 8'h03);
    idle(2);
    check(16'(secondPortPullDown), 16'h00f0);
    check(16'(firstPortPullDown), 16'h00e0);
    check(16'(debugPinPullUp), 16'h0000);
    // Released lines fall to the pull-down level
    @(posedge core_clk);
    extDrive <= 8'h00;
    idle(4);
    rdc(`SECOND_DATA_OFS, 8'h0c);
    @(posedge core_clk);
    specialSingleChip <= 1'b1;
    wr(`PULL_CTRL_OFS, 8'h40);
    rdc(`PULL_CTRL_OFS, 8'h40);
    idle(2);
    check(16'(debugPinPullUp), 16'h0001);
    check(16'({secondPortPullDown, firstPortPullDown}), 16'h0000);
    @(posedge core_clk);
    debugPinIsInput <= 1'b0;
    extDrive <= 8'hff;
    idle(2);
    check(16'(debugPinPullUp), 16'h0000);
    @(posedge core_clk);
    specialSingleChip <= 1'b0;
    wr(`PULL_CTRL_OFS, 8'h00);
    rdc(`PULL_CTRL_OFS, 8'h40);
    // Reserved and unmapped slots
    foreach (fld[i]) begin
      if (i < 3) begin
        wr(i == 0 ? 10'h002 : (i == 1 ? 10'h00e : 10'h3ff), 8'hff);
        rdc(i == 0 ? 10'h002 : (i == 1 ? 10'h00e : 10'h3ff), 8'h00);
      end
    end
    rdc(`SECOND_DIR_OFS, 8'h0f);
    // Clock output control and disable
    wr(`CLK_CTRL_OFS, 8'hff);
    rdc(`CLK_CTRL_OFS, 8'hbf);
    idle(2);
    check(16'({clkOutOe, clkOut}), 16'h0000);
    // Undivided only at 25 MHz, below the unsafe bus rate
    // kept by stimulus
    wr(`CLK_CTRL_OFS, 8'h00);
    idle(2);
    check(16'({clkOutOe, clkOutBypass}), 16'h0003);
    // Divider sweep with and without the sixteen stage
    foreach (fld[i]) begin
      wr(`CLK_CTRL_OFS, {2'b00, d16[i][0], fld[i][4:0]});
      measure(per);
      measure(per);
      check(16'(per), 16'((fld[i] + 1) * (d16[i] != 0 ? 16 : 1)));
      check(16'(clkOutBypass), 16'h0000);
    end
    report_and_stop();
  end

endmodule : port_dir_pull_clock_out_test
